/* File: sirq_periph.sv */
// peripheral end of the serial interrupt link
// assumes the host makes link_clk and the line is sampled on clk_i
`timescale 1ns/1ps
`include "sirq_cfg.svh"

module sirq_periph (
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  sirq_if.periph                 lnk,
  input  wire logic [15:0]       irq_i,
  input  wire logic              smi_i,
  input  wire logic              iochk_i,
  input  wire logic [3:0]        pci_int_i,
  output sirq_pkg::sirq_mode_e   mode_o,
  output logic                   active_o
);
  import sirq_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAMES, ST_WAIT_STOP} sirq_pst_e;

  logic                              clk_s1_q;
  logic                              clk_s2_q;
  logic                              clk_s3_q;
  logic                              line_s1_q;
  logic                              line_s2_q;
  logic                              smp_q;
  logic                              rise;
  logic                              fall;
  logic                              lo;
  logic                              start_end;
  logic [3:0]                        lowcnt_q;
  sirq_pst_e                         state_q;
  sirq_pos_s                         pos_q;
  sirq_pos_s                         nxt;
  logic                              last_frame;
  logic                              assigned;
  logic [4:0]                        idx;
  logic [`SIRQ_FRAMES_USED-1:0]      req;
  logic [`SIRQ_FRAMES_USED-1:0]      sent_q;
  logic                              line_o_q;
  logic                              line_oe_q;

  // link clock passes three flops and line two
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_s1_q  <= 1'b0;
      clk_s2_q  <= 1'b0;
      clk_s3_q  <= 1'b0;
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      clk_s1_q  <= lnk.link_clk;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      line_s1_q <= lnk.shared_interrupt_line;
      line_s2_q <= line_s1_q;
    end
  end

  assign rise = clk_s2_q & ~clk_s3_q;
  assign fall = ~clk_s2_q & clk_s3_q;

  // line level is taken mid-period, acted on at the next rising edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      smp_q <= 1'b1;
    end else if (fall) begin
      smp_q <= line_s2_q;
    end
  end

  assign lo = ~smp_q;

  // frame order for the request vector
  // channel check and pci lines follow
  assign req = {pci_int_i, iochk_i, irq_i[15:3], smi_i, irq_i[1:0]};

  // start needs four or more low clocks
  assign start_end = ~lo && (lowcnt_q >= 4'(`SIRQ_START_MIN));

  // low pulse width measured in clocks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lowcnt_q <= 4'h0;
    end else if (rise) begin
      if (!lo) begin
        lowcnt_q <= 4'h0;
      end else if (lowcnt_q != 4'hf) begin
        lowcnt_q <= lowcnt_q + 4'h1;
      end
    end
  end

  assign nxt        = sirq_advance(pos_q);
  assign last_frame = (pos_q.phase == PH_TURN) && (pos_q.frame == 6'(`SIRQ_FRAMES_USED));
  assign assigned   = (nxt.frame >= 6'h01) && (nxt.frame <= 6'(`SIRQ_FRAMES_USED));
  assign idx        = 5'(nxt.frame - 6'h01);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= ST_IDLE;
      pos_q   <= '{phase: PH_TURN, frame: 6'h00};
    end else if (rise) begin
      case (state_q)
        ST_IDLE: begin
          if (start_end) begin
            // count from the start's rising edge
            state_q <= ST_FRAMES;
            pos_q   <= '{phase: PH_TURN, frame: 6'h00};
          end
        end
        ST_FRAMES: begin
          if (last_frame) begin
            state_q <= ST_WAIT_STOP;
          end else begin
            pos_q <= nxt;
          end
        end
        ST_WAIT_STOP: begin
          if (start_end) begin
            state_q <= ST_FRAMES;
            pos_q   <= '{phase: PH_TURN, frame: 6'h00};
          end else if (!lo && (lowcnt_q == 4'(`SIRQ_STOP_QUIET) || lowcnt_q == 4'(`SIRQ_STOP_CONT))) begin
            // idle for any number of clocks
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_o <= MODE_CONT;
    end else if (rise && state_q == ST_WAIT_STOP && !lo) begin
      if (lowcnt_q == 4'(`SIRQ_STOP_QUIET)) begin
        mode_o <= MODE_QUIET;
      end else if (lowcnt_q == 4'(`SIRQ_STOP_CONT)) begin
        mode_o <= MODE_CONT;
      end
    end
  end

  // line drive, registered at each link rising edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_o_q  <= 1'b1;
      line_oe_q <= 1'b0;
    end else if (rise) begin
      line_o_q  <= 1'b1;
      line_oe_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (mode_o == MODE_QUIET && !lo && lowcnt_q == 4'h0 && req != sent_q) begin
            line_o_q  <= 1'b0;
            line_oe_q <= 1'b1;
          end
        end
        ST_FRAMES: begin
          if (!last_frame && assigned) begin
            // sample at clock 2, step of three
            // pull low for an asserted request
            if (nxt.phase == PH_SAMPLE && req[idx]) begin
              line_o_q  <= 1'b0;
              line_oe_q <= 1'b1;
            end
            if (nxt.phase == PH_RECOV) begin
              line_o_q  <= 1'b1;
              line_oe_q <= 1'b1;
            end
          end
        end
        default: begin
          line_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // last values reported, for change detection in quiet mode
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sent_q <= '0;
    end else if (rise && state_q == ST_FRAMES && !last_frame && assigned && nxt.phase == PH_SAMPLE) begin
      sent_q[idx] <= req[idx];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= (state_q != ST_IDLE);
    end
  end

  assign lnk.dev_line_o  = line_o_q;
  assign lnk.dev_line_oe = line_oe_q;

endmodule

/* File: sirq_cfg.svh */
// constants shared by both ends of the serial interrupt link
// assumes the including file runs on clk_i at the rate below
`ifndef SIRQ_CFG_SVH
`define SIRQ_CFG_SVH

`define SIRQ_CLK_PERIOD_NS   5
`define SIRQ_LINK_PERIOD_NS  80
`define SIRQ_LINK_HALF       ((`SIRQ_LINK_PERIOD_NS / `SIRQ_CLK_PERIOD_NS) / 2)

`define SIRQ_START_MIN       4
`define SIRQ_START_MAX       8
`define SIRQ_START_DEF       4
`define SIRQ_STOP_QUIET      2
`define SIRQ_STOP_CONT       3
`define SIRQ_FRAMES_USED     21
`define SIRQ_FRAMES_MAX      32

`endif

/* File: sirq_pkg.sv */
// types shared by both ends of the serial interrupt link
// assumes nothing beyond the cfg header
package sirq_pkg;

  typedef enum logic [1:0] {PH_SAMPLE, PH_RECOV, PH_TURN} sirq_phase_e;
  typedef enum logic {MODE_CONT, MODE_QUIET} sirq_mode_e;

  typedef struct packed {
    sirq_phase_e phase;
    logic [5:0]  frame;
  } sirq_pos_s;

  // step one link clock through sample, recovery and turn-around
  function automatic sirq_pos_s sirq_advance(input sirq_pos_s p);
    sirq_pos_s n;
    n = p;
    case (p.phase)
      PH_SAMPLE: n.phase = PH_RECOV;
      PH_RECOV:  n.phase = PH_TURN;
      default: begin
        n.phase = PH_SAMPLE;
        n.frame = p.frame + 6'h01;
      end
    endcase
    return n;
  endfunction

endpackage

/* File: sirq_if.sv */
// shared open-drain interrupt line and link clock
// the wire is pulled high unless one end drives it low
`timescale 1ns/1ps
interface sirq_if;
  logic link_clk;
  logic dev_line_o;
  logic dev_line_oe;
  logic host_line_o;
  logic host_line_oe;
  logic shared_interrupt_line;

  assign shared_interrupt_line = ~((dev_line_oe & ~dev_line_o) | (host_line_oe & ~host_line_o));

  modport periph (input link_clk, input shared_interrupt_line, output dev_line_o, output dev_line_oe);
  modport host (output link_clk, input shared_interrupt_line, output host_line_o, output host_line_oe);
endinterface

/* File: sirq_host.sv */
// host end of the serial interrupt link
// makes the link clock from clk_i by a divider and drives it out
`timescale 1ns/1ps
`include "sirq_cfg.svh"

module sirq_host #(
  parameter int unsigned START_W = `SIRQ_START_DEF,
  parameter int unsigned NFRAMES = `SIRQ_FRAMES_USED,
  parameter int unsigned HALF    = `SIRQ_LINK_HALF
) (
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  sirq_if.host                    lnk,
  input  wire logic               go_i,
  input  wire logic               quiet_i,
  output logic [NFRAMES-1:0]      irq_state_o,
  output logic                    done_o,
  output sirq_pkg::sirq_mode_e    mode_o
);
  import sirq_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_START, H_START_HI, H_FRAMES, H_STOP, H_STOP_HI} sirq_hst_e;

  logic [7:0]          div_q;
  logic                link_clk_q;
  logic                tog;
  logic                rise;
  logic                fall;
  logic                line_s1_q;
  logic                line_s2_q;
  logic                smp_q;
  logic                first_q;
  logic                nq_q;
  logic [3:0]          cnt_q;
  sirq_hst_e           state_q;
  sirq_pos_s           pos_q;
  logic [NFRAMES-1:0]  col_q;
  logic                line_o_q;
  logic                line_oe_q;
  logic                last_frame;

  // divider for the link clock
  assign tog  = (div_q == 8'(HALF - 1));
  assign rise = tog & ~link_clk_q;
  assign fall = tog & link_clk_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q      <= 8'h00;
      link_clk_q <= 1'b0;
    end else if (tog) begin
      div_q      <= 8'h00;
      link_clk_q <= ~link_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      smp_q     <= 1'b1;
    end else begin
      line_s1_q <= lnk.shared_interrupt_line;
      line_s2_q <= line_s1_q;
      if (fall) begin
        smp_q <= line_s2_q;
      end
    end
  end

  assign last_frame = (pos_q.phase == PH_TURN) && (pos_q.frame == 6'(NFRAMES));

  // collect frame values at mid-period of each sample phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      col_q <= '0;
    end else if (fall && state_q == H_FRAMES && pos_q.phase == PH_SAMPLE && pos_q.frame >= 6'h01
                 && pos_q.frame <= 6'(NFRAMES)) begin
      col_q[5'(pos_q.frame - 6'h01)] <= ~line_s2_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q     <= H_IDLE;
      pos_q       <= '{phase: PH_TURN, frame: 6'h00};
      cnt_q       <= 4'h0;
      first_q     <= 1'b1;
      nq_q        <= 1'b0;
      mode_o      <= MODE_CONT;
      irq_state_o <= '0;
      done_o      <= 1'b0;
      line_o_q    <= 1'b1;
      line_oe_q   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (rise) begin
        line_o_q  <= 1'b1;
        line_oe_q <= 1'b0;
        case (state_q)
          H_IDLE: begin
            if (first_q || go_i || (mode_o == MODE_QUIET && !smp_q)) begin
              state_q   <= H_START;
              first_q   <= 1'b0;
              cnt_q     <= (mode_o == MODE_QUIET && !smp_q) ? 4'h2 : 4'h1;
              line_o_q  <= 1'b0;
              line_oe_q <= 1'b1;
            end
          end
          H_START: begin
            if (cnt_q >= 4'(START_W)) begin
              state_q  <= H_START_HI;
              line_oe_q <= 1'b1;
            end else begin
              cnt_q     <= cnt_q + 4'h1;
              line_o_q  <= 1'b0;
              line_oe_q <= 1'b1;
            end
          end
          H_START_HI: begin
            state_q <= H_FRAMES;
            pos_q   <= '{phase: PH_TURN, frame: 6'h00};
          end
          H_FRAMES: begin
            if (last_frame) begin
              state_q   <= H_STOP;
              nq_q      <= quiet_i;
              cnt_q     <= 4'h1;
              line_o_q  <= 1'b0;
              line_oe_q <= 1'b1;
            end else begin
              pos_q <= sirq_advance(pos_q);
            end
          end
          H_STOP: begin
            if (cnt_q >= (nq_q ? 4'(`SIRQ_STOP_QUIET) : 4'(`SIRQ_STOP_CONT))) begin
              state_q   <= H_STOP_HI;
              line_oe_q <= 1'b1;
            end else begin
              cnt_q     <= cnt_q + 4'h1;
              line_o_q  <= 1'b0;
              line_oe_q <= 1'b1;
            end
          end
          H_STOP_HI: begin
            state_q     <= H_IDLE;
            mode_o      <= nq_q ? MODE_QUIET : MODE_CONT;
            irq_state_o <= col_q;
            done_o      <= 1'b1;
          end
          default: begin
            state_q <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign lnk.link_clk     = link_clk_q;
  assign lnk.host_line_o  = line_o_q;
  assign lnk.host_line_oe = line_oe_q;

endmodule

/* File: sirq_chk.sv */
// checker for the shared interrupt line between host and peripheral ends
// assumes link_clk comes from the host's divider on clk_i and the line idles high
`timescale 1ns/1ps
module sirq_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic link_clk,
  input wire logic dev_line_o,
  input wire logic dev_line_oe,
  input wire logic host_line_o,
  input wire logic host_line_oe,
  input wire logic shared_interrupt_line
);
  logic       lk_q;
  logic       ln_q;
  logic       in_q;
  logic       quiet_q;
  logic [7:0] low_q;
  logic [6:0] per_q;
  logic [5:0] dlo_q;
  logic [5:0] dhi_q;
  logic [5:0] hhi_q;
  logic       dev_lo;
  logic       dev_hi;
  logic       host_hi;
  logic       lk_rise;
  logic       ln_rise;

  assign dev_lo  = dev_line_oe & ~dev_line_o;
  assign dev_hi  = dev_line_oe & dev_line_o;
  assign host_hi = host_line_oe & host_line_o;
  assign lk_rise = link_clk & ~lk_q;
  assign ln_rise = shared_interrupt_line & ~ln_q;

  // edge history and run lengths, counted in clk_i cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lk_q  <= 1'b0;
      ln_q  <= 1'b1;
      low_q <= 8'h00;
      dlo_q <= 6'h00;
      dhi_q <= 6'h00;
      hhi_q <= 6'h00;
    end else begin
      lk_q  <= link_clk;
      ln_q  <= shared_interrupt_line;
      low_q <= shared_interrupt_line ? 8'h00 : low_q + {7'h00, ~&low_q};
      dlo_q <= dev_lo ? dlo_q + {5'h00, ~&dlo_q} : 6'h00;
      dhi_q <= dev_hi ? dhi_q + {5'h00, ~&dhi_q} : 6'h00;
      hhi_q <= host_hi ? hhi_q + {5'h00, ~&hhi_q} : 6'h00;
    end
  end

  // link period count from the end of the start pulse, and mode from stop width
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_q    <= 1'b0;
      quiet_q <= 1'b0;
      per_q   <= 7'h00;
    end else if (ln_rise && low_q >= 8'h3a) begin
      in_q  <= 1'b1;
      per_q <= 7'h00;
    end else begin
      if (lk_rise && per_q != 7'h7f) begin
        per_q <= per_q + 7'h01;
      end
      if (ln_rise && in_q && low_q inside {[8'h1c:8'h34]}) begin
        in_q    <= 1'b0;
        quiet_q <= low_q < 8'h28;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  no_fight_a: assert property (!(dev_hi && host_line_oe && !host_line_o) && !(host_hi && dev_lo))
    else $error("line driven high and low at once");
  pulse_width_a: assert property (ln_rise |-> low_q inside {[8'h0e:8'h12], [8'h1e:8'h22], [8'h2e:8'h32], [8'h3a:8'h82]})
    else $error("low pulse of illegal width");
  dev_low_run_a: assert property (dlo_q <= 6'h10)
    else $error("peripheral low drive longer than one period");
  dev_high_run_a: assert property (dhi_q <= 6'h10)
    else $error("peripheral high drive longer than one period");
  host_high_run_a: assert property (hhi_q <= 6'h10)
    else $error("host high drive longer than one period");
  sample_slot_a: assert property ($rose(dev_lo) && in_q |-> per_q % 7'h03 == 7'h02 && per_q <= 7'h3e)
    else $error("peripheral low outside a sample period");
  recovery_slot_a: assert property ($rose(dev_hi) && in_q |-> per_q % 7'h03 == 7'h00 && per_q != 7'h00 && per_q <= 7'h3f)
    else $error("peripheral high outside a recovery period");
  unassigned_quiet_a: assert property (in_q && per_q > 7'h40 |-> !dev_line_oe)
    else $error("peripheral drove an unassigned frame");
  cont_no_start_a: assert property (!in_q && !quiet_q |-> !dev_line_oe)
    else $error("peripheral drove line outside a cycle in continuous mode");
  idle_no_high_a: assert property (!in_q |-> !dev_hi)
    else $error("peripheral drove line high outside a cycle");

  cover property (ln_rise && in_q && low_q inside {[8'h1e:8'h22]});
  cover property ($rose(dev_lo) && !in_q);
  cover property ($rose(dev_lo) && in_q && per_q == 7'h3e);
endmodule

/* File: sirq_periph_test.sv */
// self-checking bench joining host and peripheral ends over one link
// assumes the package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
module sirq_periph_test;
  import sirq_pkg::*;
  logic        clk_i;
  logic        arst_n_i;
  logic [15:0] irq_i;
  logic        smi_i;
  logic        iochk_i;
  logic [3:0]  pci_int_i;
  logic        go_i;
  logic        quiet_i;
  sirq_mode_e  dev_mode;
  sirq_mode_e  host_mode;
  logic        active;
  logic        done;
  logic [20:0] state;
  int          err_count;
  int          checked;
  int          hits;
  logic [20:0] pats [5];

  sirq_if lnk_if ();
  sirq_periph sirq_periph_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .lnk(lnk_if), .irq_i(irq_i), .smi_i(smi_i),
    .iochk_i(iochk_i), .pci_int_i(pci_int_i), .mode_o(dev_mode), .active_o(active));
  sirq_host #(.START_W(5)) sirq_host_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .lnk(lnk_if), .go_i(go_i),
    .quiet_i(quiet_i), .irq_state_o(state), .done_o(done), .mode_o(host_mode));
  sirq_chk sirq_chk_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .link_clk(lnk_if.link_clk),
    .dev_line_o(lnk_if.dev_line_o), .dev_line_oe(lnk_if.dev_line_oe), .host_line_o(lnk_if.host_line_o),
    .host_line_oe(lnk_if.host_line_oe), .shared_interrupt_line(lnk_if.shared_interrupt_line));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bit n-1 of v is the value for frame n; irq_i[2] has no frame and is set opposite
  task automatic apply(input logic [20:0] v, input logic q);
    @(negedge clk_i);
    irq_i     = {v[15:3], ~v[2], v[1:0]};
    smi_i     = v[2];
    iochk_i   = v[16];
    pci_int_i = v[20:17];
    quiet_i   = q;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 4000) begin
      chk("cycle end", 32'h0, 32'h1);
      conclude();
    end else begin
      @(negedge clk_i);
    end
  endtask

  // counts any cycle activity over a quiet stretch after the stop settles
  task automatic idle_win();
    repeat (48) @(negedge clk_i);
    hits = 0;
    repeat (400) begin
      @(negedge clk_i);
      if (done !== 1'b0 || active !== 1'b0) hits++;
    end
  endtask

  task automatic t_reset();
    @(negedge clk_i);
    chk("reset mode", {31'h0, dev_mode}, {31'h0, MODE_CONT});
    chk("reset active", {31'h0, active}, 32'h0);
    chk("reset line", {31'h0, lnk_if.shared_interrupt_line}, 32'h1);
    wait_done();
    chk("first cycle", {11'h0, state}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_frames();
    for (int i = 0; i < 5; i++) begin
      apply(pats[i], i[0]);
      wait_done();
      wait_done();
      chk("frame map", {11'h0, state}, {11'h0, pats[i]});
      repeat (40) @(negedge clk_i);
      chk("dev mode", {31'h0, dev_mode}, {31'h0, i[0] ? MODE_QUIET : MODE_CONT});
      chk("host mode", {31'h0, host_mode}, {31'h0, i[0] ? MODE_QUIET : MODE_CONT});
    end
    $display("test frames done");
  endtask

  task automatic t_quiet();
    apply(pats[4], 1'b1);
    go_i = 1'b0;
    wait_done();
    idle_win();
    chk("no change no start", hits, 32'h0);
    apply(pats[1], 1'b0);
    wait_done();
    chk("quiet start data", {11'h0, state}, {11'h0, pats[1]});
    $display("test quiet done");
  endtask

  task automatic t_cont();
    idle_win();
    chk("cont mode", {31'h0, dev_mode}, {31'h0, MODE_CONT});
    apply(pats[2], 1'b0);
    idle_win();
    chk("cont no start", hits, 32'h0);
    $display("test cont done");
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    err_count = 0;
    checked   = 0;
    arst_n_i  = 1'b0;
    go_i      = 1'b1;
    quiet_i   = 1'b0;
    irq_i     = 16'h0000;
    smi_i     = 1'b0;
    iochk_i   = 1'b0;
    pci_int_i = 4'h0;
    pats      = '{21'h000000, 21'h1fffff, 21'h155555, 21'h0aaaaa, 21'h100001};
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    t_reset();
    t_frames();
    t_quiet();
    t_cont();
    conclude();
  end
endmodule
